// ### common/axis_pkg.sv
// axis_pkg: register map, field positions, reset values and timing for the axis output stage
// assumes a single 50 MHz pclk domain
package axis_pkg;

    // clock and pwm timing
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned PWM_INV_HZ    = 64_000;
    localparam int unsigned PWM_SM_HZ     = 128_000;
    localparam int unsigned PWM_INV_STEPS = 500;
    localparam int unsigned PWM_SM_STEPS  = PWM_INV_STEPS * PWM_INV_HZ / PWM_SM_HZ;
    localparam int unsigned PWM_TICK_HZ   = PWM_INV_HZ * PWM_INV_STEPS;

    localparam logic [25:0] ACC_ADD   = 26'(PWM_TICK_HZ);
    localparam logic [25:0] ACC_WRAP  = 26'(CLK_HZ);
    localparam logic [8:0]  INV_LAST  = 9'(PWM_INV_STEPS - 1);
    localparam logic [8:0]  SM_LAST   = 9'(PWM_SM_STEPS - 1);
    // inverter: 1..499 of 500 high counts, sign-magnitude: 0..249 of 250
    localparam logic [8:0]  INV_MID   = 9'(PWM_INV_STEPS / 2);
    localparam logic [8:0]  DUTY_SPAN = 9'(PWM_SM_STEPS - 1);
    localparam int unsigned CMD_SHIFT = 15;

    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_OFFLVL  = 8'h04;
    localparam logic [7:0] OFF_ERRLIM  = 8'h08;
    localparam logic [7:0] OFF_SAMPLE  = 8'h0c;
    localparam logic [7:0] OFF_STEP    = 8'h10;
    localparam logic [7:0] OFF_OUTSET  = 8'h14;
    localparam logic [7:0] OFF_OUTCLR  = 8'h18;
    localparam logic [7:0] OFF_OUTPORT = 8'h1c;
    localparam logic [7:0] OFF_STATUS  = 8'h20;
    localparam logic [7:0] OFF_MASK    = 8'h24;
    localparam logic [7:0] OFF_STATE   = 8'h28;

    // control register bits
    localparam int CTL_MOTOR_ON  = 0;
    localparam int CTL_SM_SEL    = 1;
    localparam int CTL_STEPPER   = 2;
    localparam int CTL_EN_LOW    = 3;
    localparam int CTL_DOE       = 4;
    localparam int CTL_STEP_HIGH = 5;
    localparam int CTL_STEP_DIR  = 6;
    localparam int CTL_STEP_RUN  = 7;
    localparam int CTL_AMP_EN    = 8;
    localparam int CTL_W         = 9;

    // status / mask bits
    localparam int ST_ABORT  = 0;
    localparam int ST_ERR    = 1;
    localparam int ST_SAMPLE = 2;
    localparam int ST_W      = 3;

    // reset values
    localparam logic [CTL_W-1:0] CTRL_RST   = 9'h000;
    localparam logic [15:0]      SAMPLE_RST = 16'hc350;
    localparam logic [15:0]      STEP_RST   = 16'h0019;
    localparam logic [31:0]      ERRLIM_RST = 32'h0000_4000;

endpackage

// ### common/pwm_if.sv
// pwm_if: command and mode from the axis stage to the pwm generator, pwm level back
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface pwm_if;
    logic signed [15:0] duty_cmd;
    logic               sm_mode;
    logic               load;
    logic               pwm_out;
    modport ctrl (output duty_cmd, output sm_mode, output load, input pwm_out);
    modport gen  (input duty_cmd, input sm_mode, input load, output pwm_out);
endinterface
`default_nettype wire

// ### tb/amp_model.sv
// amp_model: external amplifier or step driver that watches the axis stage pins
// assumes pwm_step, sign_dir and amp_enable are settled registers on clk
`timescale 1ns/1ps
`default_nettype none
module amp_model (
    // clock
    input wire logic clk,
    // pins from the axis stage
    input wire logic pwm_step,
    input wire logic sign_dir,
    input wire logic amp_enable
);
    // the bridge only averages, so a high count over whole periods is all it sees
    task automatic measure(input int n, output int highs);
        highs = 0;
        repeat (n) begin
            @(posedge clk);
            if (pwm_step === 1'b1) begin
                highs++;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### tb/axis_output_stage_tb.sv
// axis_output_stage_tb: apb driven checks of the axis output pins
// assumes a 50 MHz pclk and the amp_model partner on the pins
`timescale 1ns/1ps
`default_nettype none
module axis_output_stage_tb;
    import axis_pkg::*;
    logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, abort_n = 1;
    logic        [7:0]  paddr = 0;
    logic        [31:0] pwdata = 0, prdata, rd;
    logic               pready, pslverr, last_err, pwm_step, sign_dir, amp_enable, error_n, irq;
    logic signed [15:0] cmd_in = 0;
    logic signed [31:0] pos_err = 0;
    logic        [15:0] motor_cmd;
    logic        [7:0]  gp_out;
    int                 fails = 0, samples_checked = 0, cycles = 0, h;
    logic        [15:0] tc [7] = '{16'h8001, 16'h0000, 16'h7fff, 16'h4000, 16'h0000, 16'h7fff, 16'hc000};
    int                 te [7] = '{2, 500, 998, 749, 0, 996, 498};
    localparam int AE = 1 << CTL_AMP_EN;
    localparam int ST = (1 << CTL_STEPPER) | (1 << CTL_STEP_RUN);

    always #10 pclk = ~pclk;

    axis_output_stage i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_in(cmd_in),
        .pos_err(pos_err), .abort_n(abort_n), .motor_cmd(motor_cmd), .pwm_step(pwm_step), .sign_dir(sign_dir),
        .amp_enable(amp_enable), .error_n(error_n), .gp_out(gp_out), .irq(irq));
    amp_model i_amp (.clk(pclk), .pwm_step(pwm_step), .sign_dir(sign_dir), .amp_enable(amp_enable));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the tests need about 28550 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // entered just after a rising edge; ends one idle edge later so the next setup never collides
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, 32'(d));
    endtask

    task automatic rdchk(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk(rd, 32'(exp));
    endtask

    function automatic logic [31:0] near(input int a, input int b);
        return 32'((a - b <= 3) && (b - a <= 3));
    endfunction

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(OFF_CTRL, 0);
        rdchk(OFF_SAMPLE, 'hc350);
        rdchk(OFF_STEP, 'h19);
        rdchk(OFF_ERRLIM, 'h4000);
        chk(32'(amp_enable), 0);
        apb(1'b0, 8'h30, 32'h0);
        chk(32'(last_err), 1);
        chk(32'(pready), 1);
        $display("reset and map test done");
        wr(OFF_OUTPORT, 'ha5);
        chk(32'(gp_out), 'ha5);
        wr(OFF_OUTSET, 3);
        wr(OFF_OUTSET, 1);
        chk(32'(gp_out), 'haf);
        wr(OFF_OUTCLR, 7);
        wr(OFF_OUTCLR, 0);
        chk(32'(gp_out), 'h2e);
        $display("general output test done");
        wr(OFF_SAMPLE, 20);
        wr(OFF_OFFLVL, 'h1234);
        cmd_in <= 16'sh0777;
        cyc(30);
        chk(32'(motor_cmd), 'h1234);
        wr(OFF_CTRL, 1 << CTL_MOTOR_ON);
        cmd_in <= -16'sd100;
        cyc(24);
        chk(32'(motor_cmd), 'hff9c);
        chk(32'(sign_dir), 1);
        cmd_in <= 16'sh0100;
        cyc(24);
        chk(32'(motor_cmd), 'h0100);
        chk(32'(sign_dir), 0);
        // 3125 cycles span exactly four inverter or eight sign-magnitude periods
        for (int i = 0; i < 7; i++) begin
            wr(OFF_CTRL, (1 << CTL_MOTOR_ON) | (int'(i > 3) << CTL_SM_SEL));
            cmd_in <= tc[i];
            cyc(900);
            i_amp.measure(3125, h);
            chk(near(h * 8 / 25, te[i]), 1);
        end
        chk(32'(sign_dir), 1);
        $display("servo and pwm test done");
        wr(OFF_CTRL, AE);
        chk(32'(amp_enable), 1);
        wr(OFF_CTRL, AE | (1 << CTL_EN_LOW));
        chk(32'(amp_enable), 0);
        wr(OFF_STATUS, 7);
        wr(OFF_MASK, 1 << ST_ABORT);
        abort_n <= 1'b0;
        cyc(8);
        chk(32'(amp_enable), 1);
        chk(32'(irq), 1);
        abort_n <= 1'b1;
        wr(OFF_STATUS, 1 << ST_ABORT);
        chk(32'(irq), 0);
        rdchk(OFF_CTRL, 1 << CTL_EN_LOW);
        wr(OFF_CTRL, AE);
        pos_err <= 32'sh5000;
        cyc(3);
        chk(32'(amp_enable), 1);
        pos_err <= 32'sh4000;
        wr(OFF_CTRL, AE | (1 << CTL_DOE));
        chk(32'({error_n, amp_enable}), 3);
        pos_err <= 32'sh4001;
        cyc(3);
        chk(32'({error_n, amp_enable}), 0);
        pos_err <= -32'sh5000;
        cyc(3);
        chk(32'(error_n), 0);
        pos_err <= 0;
        cyc(3);
        chk(32'(error_n), 1);
        $display("enable and error test done");
        wr(OFF_STEP, 4);
        wr(OFF_CTRL, ST | (1 << CTL_STEP_HIGH) | (1 << CTL_STEP_DIR));
        i_amp.measure(80, h);
        chk(32'(h), 40);
        chk(32'(sign_dir), 1);
        wr(OFF_CTRL, ST);
        i_amp.measure(80, h);
        chk(32'(h), 40);
        chk(32'(sign_dir), 0);
        wr(OFF_CTRL, 1 << CTL_STEPPER);
        cyc(2);
        chk(32'(pwm_step), 1);
        wr(OFF_CTRL, (1 << CTL_STEPPER) | (1 << CTL_STEP_HIGH));
        cyc(2);
        chk(32'(pwm_step), 0);
        $display("stepper test done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ### verilog/axis_output_stage.sv
// axis_output_stage: motor command, pwm/step, sign, amp enable, error and eight outputs
// assumes an apb master on pclk; cmd_in and pos_err come from logic on pclk
// Function
// RQ1: in servo mode the motor command is refreshed once every servo sample period.
// RQ2: while the motor is off the motor command holds the programmed motor-off level.
// RQ3: amp enable drops to disabled on abort, and on error when disable-on-error is set.
// RQ4: amp enable polarity is selectable, active high by default.
// RQ5: inverter pwm runs at 64 kHz from 0.2% to 99.8% duty with 50% at zero.
// RQ6: sign-magnitude pwm runs at 128 kHz from 0% to 99.6% with the sign on the sign pin.
// RQ7: stepper axes get a 50% step pulse train with selectable active level.
// RQ8: the sign pin carries the command sign for servo and the direction for stepper.
// RQ9: the error pin goes low while the position error exceeds the error limit.
// RQ10: eight general outputs are set or cleared one bit at a time.
// RQ11: a whole-port write loads all eight general outputs at once.
// RQ12: pwm duty follows the signed command linearly and updates each sample; in sign-magnitude mode the code scales the command magnitude instead.
`timescale 1ns/1ps
`default_nettype none
module axis_output_stage import axis_pkg::*; (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    // controller side
    input  wire logic signed [15:0] cmd_in,
    input  wire logic signed [31:0] pos_err,
    // pins in
    input  wire logic               abort_n,
    // pins out
    output var  logic [15:0]        motor_cmd,
    output var  logic               pwm_step,
    output var  logic               sign_dir,
    output var  logic               amp_enable,
    output var  logic               error_n,
    output var  logic [7:0]         gp_out,
    // interrupt
    output var  logic               irq
);
    typedef struct packed {
        logic [2:0]        abort_sync;
        logic              abort_lvl;
        logic              err_lvl;
        logic [CTL_W-1:0]  ctrl;
        logic [15:0]       off_level;
        logic [31:0]       err_limit;
        logic [15:0]       sample_period;
        logic [15:0]       sample_cnt;
        logic              sample_tick;
        logic [15:0]       step_half;
        logic [15:0]       step_cnt;
        logic              step_phase;
        logic [7:0]        outputs;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic [15:0]       motor_cmd;
        logic              sign_out;
        logic              pwm_pin;
        logic              amp_pin;
        logic              err_pin;
        logic [31:0]       rdata;
        logic              rerr;
    } axis_state_t;

    axis_state_t     s;
    axis_state_t     next_s;
    pwm_if           pb ();
    logic            wr;
    logic            setup;
    logic            tick;
    logic            err_now;
    logic            abort_hit;
    logic            err_rise;
    logic            step_wrap;
    logic [ST_W-1:0] w1c;
    logic [ST_W-1:0] events;

    // register decode, used only for the slave error; read mux and write path decode paddr in their own case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, OFF_CTRL) || hit(a, OFF_OFFLVL) || hit(a, OFF_ERRLIM) ||
                 hit(a, OFF_SAMPLE) || hit(a, OFF_STEP) || hit(a, OFF_OUTSET) ||
                 hit(a, OFF_OUTCLR) || hit(a, OFF_OUTPORT) || hit(a, OFF_STATUS) ||
                 hit(a, OFF_MASK) || hit(a, OFF_STATE);
    endfunction

    function automatic logic over_limit(input logic signed [31:0] e, input logic [31:0] lim);
        logic [31:0] m;
        m = e[31] ? 32'(-e) : 32'(e);
        over_limit = m > lim;
    endfunction

    pwm_gen u_pwm (
        .clk   (pclk),
        .rst_n (presetn),
        .pb    (pb.gen)
    );

    assign pb.duty_cmd = s.motor_cmd;
    assign pb.sm_mode  = s.ctrl[CTL_SM_SEL];
    assign pb.load     = s.sample_tick;

    always_comb begin
        next_s = s;
        wr     = psel && penable && pwrite;
        setup  = psel && !penable;

        // abort pin: three stages, a change counts once stages two and three agree
        next_s.abort_sync = {s.abort_sync[1:0], abort_n};
        abort_hit = (s.abort_sync[1] == s.abort_sync[2]) && !s.abort_sync[2] && s.abort_lvl;
        if (s.abort_sync[1] == s.abort_sync[2]) begin
            next_s.abort_lvl = s.abort_sync[2];
        end

        err_now        = over_limit(pos_err, s.err_limit);
        err_rise       = err_now && !s.err_lvl;
        next_s.err_lvl = err_now;
        next_s.err_pin = !err_now; // see RQ9

        // servo sample divider
        tick = (s.sample_cnt + 16'h0001) >= s.sample_period;
        next_s.sample_cnt  = tick ? 16'h0000 : s.sample_cnt + 16'h0001;
        next_s.sample_tick = tick;

        if (!s.ctrl[CTL_MOTOR_ON]) begin
            next_s.motor_cmd = s.off_level; // see RQ2
        end else if (tick) begin
            next_s.motor_cmd = cmd_in; // see RQ1
        end

        // step train: phase toggles every half period, so the pulse is half the period
        step_wrap = (s.step_cnt + 16'h0001) >= s.step_half;
        if (s.ctrl[CTL_STEPPER] && s.ctrl[CTL_STEP_RUN]) begin
            next_s.step_cnt = step_wrap ? 16'h0000 : s.step_cnt + 16'h0001;
            if (step_wrap) begin
                next_s.step_phase = !s.step_phase; // see RQ7
            end
        end else begin
            next_s.step_cnt   = 16'h0000;
            next_s.step_phase = 1'b0;
        end

        if (s.ctrl[CTL_STEPPER]) begin
            next_s.pwm_pin  = s.ctrl[CTL_STEP_HIGH] ? s.step_phase : !s.step_phase; // see RQ7
            next_s.sign_out = s.ctrl[CTL_STEP_DIR]; // see RQ8
        end else begin
            next_s.pwm_pin  = pb.pwm_out;
            next_s.sign_out = s.motor_cmd[15]; // see RQ6 // see RQ8
        end

        // register writes take effect at the access edge
        w1c = '0;
        if (wr) begin
            case (paddr)
                OFF_CTRL:    next_s.ctrl          = pwdata[CTL_W-1:0];
                OFF_OFFLVL:  next_s.off_level     = pwdata[15:0];
                OFF_ERRLIM:  next_s.err_limit     = pwdata;
                OFF_SAMPLE:  next_s.sample_period = pwdata[15:0];
                OFF_STEP:    next_s.step_half     = pwdata[15:0];
                OFF_OUTSET:  next_s.outputs[pwdata[2:0]] = 1'b1; // see RQ10
                OFF_OUTCLR:  next_s.outputs[pwdata[2:0]] = 1'b0; // see RQ10
                OFF_OUTPORT: next_s.outputs       = pwdata[7:0]; // see RQ11
                OFF_STATUS:  w1c                  = pwdata[ST_W-1:0];
                OFF_MASK:    next_s.mask          = pwdata[ST_W-1:0];
                default:     w1c                  = '0;
            endcase
        end

        // hardware disable overrides a software write in the same cycle
        if (abort_hit || (s.ctrl[CTL_DOE] && err_now)) begin
            next_s.ctrl[CTL_AMP_EN] = 1'b0; // see RQ3
        end
        next_s.amp_pin = next_s.ctrl[CTL_AMP_EN] ^ next_s.ctrl[CTL_EN_LOW]; // see RQ4

        // sticky status: a new event wins over a clear in the same cycle
        events = '0;
        events[ST_ABORT]  = abort_hit;
        events[ST_ERR]    = err_rise;
        events[ST_SAMPLE] = tick;
        next_s.status = (s.status & ~w1c) | events;

        // read data captured in the setup cycle, shown in the access cycle
        if (setup) begin
            next_s.rerr = !mapped(paddr);
            case (paddr)
                OFF_CTRL:    next_s.rdata = 32'(s.ctrl);
                OFF_OFFLVL:  next_s.rdata = 32'(s.off_level);
                OFF_ERRLIM:  next_s.rdata = s.err_limit;
                OFF_SAMPLE:  next_s.rdata = 32'(s.sample_period);
                OFF_STEP:    next_s.rdata = 32'(s.step_half);
                OFF_OUTPORT: next_s.rdata = 32'(s.outputs);
                OFF_STATUS:  next_s.rdata = 32'(s.status);
                OFF_MASK:    next_s.rdata = 32'(s.mask);
                OFF_STATE:   next_s.rdata = 32'({s.abort_lvl, s.err_lvl, s.pwm_pin, s.amp_pin});
                default:     next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s               <= '0;
            s.abort_sync    <= 3'h7;
            s.abort_lvl     <= 1'b1;
            s.ctrl          <= CTRL_RST;
            s.err_limit     <= ERRLIM_RST;
            s.sample_period <= SAMPLE_RST;
            s.step_half     <= STEP_RST;
            s.err_pin       <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // zero wait states; unmapped addresses answer with pslverr
    assign pready     = 1'b1;
    assign prdata     = s.rdata;
    assign pslverr    = s.rerr;
    assign motor_cmd  = s.motor_cmd;
    assign pwm_step   = s.pwm_pin;
    assign sign_dir   = s.sign_out;
    assign amp_enable = s.amp_pin;
    assign error_n    = s.err_pin;
    assign gp_out     = s.outputs;
    assign irq        = |(s.status & s.mask);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_wr(logic [7:0] off);
        psel && penable && pwrite && paddr == off;
    endsequence

    sequence abort_seen;
        s.abort_lvl ##1 !s.abort_lvl;
    endsequence

    cmd_refresh_a: assert property (s.ctrl[CTL_MOTOR_ON] && tick |=> motor_cmd == $past(cmd_in)) // see RQ1
        else $error("motor command missed the sample refresh");
    cmd_hold_a: assert property (s.ctrl[CTL_MOTOR_ON] && !tick |=> $stable(motor_cmd)) // see RQ1
        else $error("motor command changed between samples");
    off_level_a: assert property (!s.ctrl[CTL_MOTOR_ON] |=> motor_cmd == $past(s.off_level)) // see RQ2
        else $error("motor off did not hold the off level");
    abort_drop_a: assert property (abort_seen |-> !s.ctrl[CTL_AMP_EN] && amp_enable == s.ctrl[CTL_EN_LOW]) // see RQ3
        else $error("amp enable not dropped on abort");
    amp_pol_a: assert property (##1 amp_enable == (s.ctrl[CTL_AMP_EN] ^ s.ctrl[CTL_EN_LOW])) // see RQ4
        else $error("amp enable polarity wrong");
    err_pin_a: assert property (over_limit(pos_err, s.err_limit) |=> !error_n ##1 1'b1) // see RQ9
        else $error("error pin not low on excess error");
    step_dir_a: assert property (s.ctrl[CTL_STEPPER] |=> sign_dir == $past(s.ctrl[CTL_STEP_DIR])) // see RQ8
        else $error("direction pin does not follow step direction");
    set_bit_a: assert property (apb_wr(OFF_OUTSET) |=> gp_out[$past(pwdata[2:0])]) // see RQ10
        else $error("set bit did not drive the output");
    clr_bit_a: assert property (apb_wr(OFF_OUTCLR) |=> !gp_out[$past(pwdata[2:0])]) // see RQ10
        else $error("clear bit did not release the output");
    port_wr_a: assert property (apb_wr(OFF_OUTPORT) |=> gp_out == $past(pwdata[7:0])) // see RQ11
        else $error("port write not loaded");
    step_half_a: assert property (s.ctrl[CTL_STEPPER] && s.ctrl[CTL_STEP_RUN] && step_wrap
                                  ##1 s.ctrl[CTL_STEPPER] && s.ctrl[CTL_STEP_RUN]
                                  |-> s.step_phase != $past(s.step_phase) && s.step_cnt == 16'h0000) // see RQ7
        else $error("step phase did not toggle at half period");
endmodule
`default_nettype wire

// ### verilog/pwm_gen.sv
// pwm_gen: inverter and sign-magnitude pwm at a 32 MHz count enable
// assumes load pulses once per servo sample with a settled duty_cmd
`timescale 1ns/1ps
`default_nettype none
module pwm_gen import axis_pkg::*; (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // command side
    pwm_if.gen        pb
);
    typedef struct packed {
        logic [25:0] acc;
        logic [8:0]  cnt;
        logic [8:0]  high;
        logic        out;
    } pwm_state_t;

    // half an lsb of the scaled command, so full scale rounds onto the end counts
    localparam int CMD_HALF = 1 << (CMD_SHIFT - 1);

    pwm_state_t s;
    pwm_state_t next_s;
    logic       tick;
    logic [8:0] last;

    // signed command scaled into high counts
    function automatic logic [8:0] duty_of(input logic signed [15:0] c, input logic sm);
        logic signed [25:0] p;
        logic [15:0]        m;
        p = 26'(c) * 26'(DUTY_SPAN);
        m = c[15] ? 16'(-c) : 16'(c);
        if (sm) begin
            duty_of = 9'((25'(m) * 25'(DUTY_SPAN) + 25'(CMD_HALF)) >> CMD_SHIFT);
        end else begin
            duty_of = 9'(INV_MID + 9'((p + 26'(CMD_HALF)) >>> CMD_SHIFT));
        end
    endfunction

    always_comb begin
        next_s = s;
        last = pb.sm_mode ? SM_LAST : INV_LAST;
        // one bit of headroom: acc plus the step can pass the 26-bit range
        tick = (27'(s.acc) + 27'(ACC_ADD)) >= 27'(ACC_WRAP);
        // fractional divider: 16 count enables per 25 clocks, no drift
        next_s.acc = tick ? s.acc + ACC_ADD - ACC_WRAP : s.acc + ACC_ADD;
        if (tick) begin
            next_s.cnt = (s.cnt >= last) ? 9'h000 : s.cnt + 9'h001; // see RQ5 // see RQ6
        end
        if (pb.load) begin
            next_s.high = duty_of(pb.duty_cmd, pb.sm_mode); // see RQ12
        end
        next_s.out = s.cnt < s.high;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{acc: 26'h0, cnt: 9'h000, high: INV_MID, out: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign pb.pwm_out = s.out;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    inv_range_a: assert property (pb.load && !pb.sm_mode |=> s.high >= 9'h001 && s.high <= INV_LAST) // see RQ5
        else $error("inverter duty outside its range");
    sm_range_a: assert property (pb.load && pb.sm_mode |=> s.high <= SM_LAST) // see RQ6
        else $error("sign-magnitude duty reaches full on");
    wrap_cnt_a: assert property (tick && s.cnt == last |=> s.cnt == 9'h000) // see RQ5
        else $error("pwm counter did not wrap at period end");
endmodule
`default_nettype wire
